/* logic/diag_pkg.sv */
// Constants, register map and carrier types of the fault and diagnosis block
package diag_pkg;

  localparam int NUM_CH = 8;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // Clock rate and timing
  localparam int CLK_MHZ = 20;
  localparam int SYNC_LAT = 3;
  localparam int OPEN_LOAD_DELAY_MIN_US = 100;
  localparam int OPEN_LOAD_DELAY_MAX_US = 250;
  localparam int OVERLOAD_OFF_DELAY_MAX_US = 60;
  // Least open-load delay, rounded up to whole cycles
  localparam int OPEN_LOAD_CYCLES = OPEN_LOAD_DELAY_MIN_US * CLK_MHZ;
  // Longest overload delay, less synchroniser and flag register latency
  localparam int OVERLOAD_CYCLES = OVERLOAD_OFF_DELAY_MAX_US * CLK_MHZ - SYNC_LAT - 2;

  // Register offsets
  localparam logic [ADDR_W-1:0] REG_DIAG01 = 4'h0;
  localparam logic [ADDR_W-1:0] REG_DIAG23 = 4'h1;
  localparam logic [ADDR_W-1:0] REG_DIAG45 = 4'h2;
  localparam logic [ADDR_W-1:0] REG_DIAG67 = 4'h3;
  localparam logic [ADDR_W-1:0] REG_CMD = 4'h4;
  localparam logic [ADDR_W-1:0] REG_DIAG_CURRENT_CFG = 4'h5;
  localparam logic [ADDR_W-1:0] REG_CHAN_STATE = 4'h6;
  localparam logic [ADDR_W-1:0] REG_INT_STATUS = 4'h7;
  localparam logic [ADDR_W-1:0] REG_INT_MASK = 4'h8;

  // Field positions
  localparam int CMD_CPL_BIT = 0;
  localparam int DIAG_PROT_EVEN_BIT = 0;
  localparam int DIAG_OL_EVEN_BIT = 1;
  localparam int DIAG_PROT_ODD_BIT = 2;
  localparam int DIAG_OL_ODD_BIT = 3;
  localparam int INT_PROT_BIT = 0;
  localparam int INT_OL_BIT = 1;

  // Values after reset
  localparam logic [DATA_W-1:0] DIAG_CURRENT_RST = 8'h00;
  localparam logic [DATA_W-1:0] INT_MASK_RST = 8'h00;
  localparam logic [DATA_W-1:0] INT_STATUS_RST = 8'h00;

  // Register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // Analog fault indications of all channels
  typedef struct packed {
    logic [NUM_CH-1:0] overload;
    logic [NUM_CH-1:0] overtemp;
    logic [NUM_CH-1:0] open_load;
  } fault_in_t;

endpackage

/* logic/sync3.sv */
// Three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/100ps
module sync3 import diag_pkg::*; #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] s1_q, s2_q, s3_q, out_q;
  logic [WIDTH-1:0] out_d;

  always_comb begin
    out_d = out_q;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        out_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign dout = out_q;

endmodule

/* logic/qual_timer.sv */
// Qualification timer: reports a condition once it held for COUNT cycles in a row
`timescale 1ns/100ps
module qual_timer import diag_pkg::*; #(
  parameter int COUNT = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Condition and result
  input wire logic cond,
  output logic done
);

  localparam int W = $clog2(COUNT + 1);
  localparam logic [W-1:0] LAST = W'(COUNT);

  logic [W-1:0] cnt_q, cnt_d;

  if (COUNT < 1) begin : g_check
    $error("qual_timer COUNT must be at least one");
  end

  always_comb begin
    if (!cond) begin
      cnt_d = '0;
    end else if (cnt_q != LAST) begin
      cnt_d = cnt_q + W'(1);
    end else begin
      cnt_d = cnt_q;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign done = cond && (cnt_q == LAST);

  timer_restart_a: assert property (@(posedge clock) disable iff (rst) !cond |=> cnt_q == '0)
    else $error("timer did not restart after condition dropped");

endmodule

/* logic/power_switch_fault_diagnosis.sv */
// Fault latching, open-load diagnosis and register file of an eight-channel power switch
// Behaviour
// - Each channel latches overload or over-temperature shutdown until cleared.
// - Writing the clear command bit as one clears all protection flags except those whose fault event is present in that cycle.
// - The clear command bit returns to zero at the next accepted frame.
// - Each channel latches detected open load until the flag is cleared.
// - Reading a diagnosis register clears its open-load flags after capturing them.
// - No open-load detection and no open-load flag while a channel is on; a flag latched while off stays set after the channel turns on.
// - Off channel sets open-load flag after comparator holds the qualification delay.
// - Per-channel enable bit written as one turns on the diagnosis current.
// - Over-temperature sets the protection flag and forces an active channel off.
// - Sustained overload on an active channel turns it off within 60 us.
// - A protected channel stays off until the clear command clears its latch.
// - Over-temperature also sets the protection flag while the channel is off.
// - Four diagnosis registers hold two channels each in bits zero to three.
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/100ps
module power_switch_fault_diagnosis import diag_pkg::*; #(
  parameter int CHANNELS = NUM_CH
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire reg_req_t reg_req,
  output logic [DATA_W-1:0] rd_data,
  // Serial frame accepted
  input wire logic frame_valid,
  // Channel requests from the input selection
  input wire logic [NUM_CH-1:0] ch_request,
  // Analog fault comparators
  input wire fault_in_t fault_pins,
  // Channel control and diagnosis
  output logic [NUM_CH-1:0] ch_on,
  output logic [NUM_CH-1:0] diag_current_enable,
  output logic [NUM_CH-1:0] protect_fault_flag,
  output logic [NUM_CH-1:0] open_load_flag,
  // Interrupt
  output logic irq
);

  if (CHANNELS != NUM_CH) begin : g_check
    $error("power_switch_fault_diagnosis serves exactly eight channels");
  end

  // Synchronised comparator levels
  fault_in_t fault_s;
  logic [NUM_CH-1:0] ovl_s, ot_s, ol_s;

  sync3 #(
    .WIDTH(3 * NUM_CH)
  ) u_sync (
    .clock(clock),
    .rst(rst),
    .din(fault_pins),
    .dout(fault_s)
  );

  assign ovl_s = fault_s.overload;
  assign ot_s = fault_s.overtemp;
  assign ol_s = fault_s.open_load;

  // Channel state and latched flags
  logic [NUM_CH-1:0] prot_q, prot_d;
  logic [NUM_CH-1:0] ol_q, ol_d;
  logic [NUM_CH-1:0] on_q, on_d;
  logic [NUM_CH-1:0] ovl_cond, ovl_done;
  logic [NUM_CH-1:0] ol_cond, ol_done;
  logic [NUM_CH-1:0] prot_set, ol_set, ol_clr;

  // Qualification timers, one pair per channel
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    assign ovl_cond[i] = ovl_s[i] && on_q[i];
    assign ol_cond[i] = ol_s[i] && !on_q[i];

    qual_timer #(
      .COUNT(OVERLOAD_CYCLES)
    ) u_ovl (
      .clock(clock),
      .rst(rst),
      .cond(ovl_cond[i]),
      .done(ovl_done[i])
    );

    qual_timer #(
      .COUNT(OPEN_LOAD_CYCLES)
    ) u_ol (
      .clock(clock),
      .rst(rst),
      .cond(ol_cond[i]),
      .done(ol_done[i])
    );
  end

  // Register decode
  logic cpl_clr;
  logic diag_rd;
  logic [1:0] diag_idx;

  assign cpl_clr = reg_req.wr && (reg_req.addr == REG_CMD) && reg_req.wdata[CMD_CPL_BIT];
  assign diag_rd = reg_req.rd && (reg_req.addr[ADDR_W-1:2] == REG_DIAG01[ADDR_W-1:2]);
  assign diag_idx = reg_req.addr[1:0];

  // Protection and open-load latches
  always_comb begin
    prot_set = ot_s | ovl_done;
    ol_set = ol_done & ~on_q;
    ol_clr = '0;
    if (diag_rd) begin
      ol_clr[2 * diag_idx] = 1'b1;
      ol_clr[2 * diag_idx + 1] = 1'b1;
    end
    if (cpl_clr) begin
      prot_d = prot_set;
    end else begin
      prot_d = prot_q | prot_set;
    end
    ol_d = (ol_q & ~ol_clr) | ol_set;
    on_d = ch_request & ~prot_d;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prot_q <= '0;
      ol_q <= '0;
      on_q <= '0;
    end else begin
      prot_q <= prot_d;
      ol_q <= ol_d;
      on_q <= on_d;
    end
  end

  // Command and configuration registers
  logic cpl_q, cpl_d;
  logic [NUM_CH-1:0] dcc_q, dcc_d;
  logic [DATA_W-1:0] mask_q, mask_d;

  always_comb begin
    cpl_d = cpl_q;
    if (cpl_clr) begin
      cpl_d = 1'b1;
    end else if (frame_valid) begin
      cpl_d = 1'b0;
    end
    dcc_d = dcc_q;
    if (reg_req.wr && (reg_req.addr == REG_DIAG_CURRENT_CFG)) begin
      dcc_d = reg_req.wdata;
    end
    mask_d = mask_q;
    if (reg_req.wr && (reg_req.addr == REG_INT_MASK)) begin
      mask_d = reg_req.wdata;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cpl_q <= 1'b0;
      dcc_q <= DIAG_CURRENT_RST;
      mask_q <= INT_MASK_RST;
    end else begin
      cpl_q <= cpl_d;
      dcc_q <= dcc_d;
      mask_q <= mask_d;
    end
  end

  // Interrupt status, set wins over write-one-to-clear
  logic [DATA_W-1:0] stat_q, stat_d;
  logic [DATA_W-1:0] stat_ev;
  logic [DATA_W-1:0] stat_w1c;

  always_comb begin
    stat_ev = '0;
    stat_ev[INT_PROT_BIT] = |(prot_set & ~prot_q);
    stat_ev[INT_OL_BIT] = |(ol_set & ~ol_q);
    stat_w1c = '0;
    if (reg_req.wr && (reg_req.addr == REG_INT_STATUS)) begin
      stat_w1c = reg_req.wdata;
    end
    stat_d = (stat_q & ~stat_w1c) | stat_ev;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stat_q <= INT_STATUS_RST;
    end else begin
      stat_q <= stat_d;
    end
  end

  // Read data, standing only in the cycle after the read strobe
  logic [DATA_W-1:0] rd_q, rd_d;
  logic irq_q, irq_d;

  always_comb begin
    rd_d = '0;
    if (reg_req.rd) begin
      case (reg_req.addr)
        REG_DIAG01, REG_DIAG23, REG_DIAG45, REG_DIAG67: begin
          rd_d[DIAG_PROT_EVEN_BIT] = prot_q[2 * diag_idx];
          rd_d[DIAG_OL_EVEN_BIT] = ol_q[2 * diag_idx];
          rd_d[DIAG_PROT_ODD_BIT] = prot_q[2 * diag_idx + 1];
          rd_d[DIAG_OL_ODD_BIT] = ol_q[2 * diag_idx + 1];
        end
        REG_CMD: begin
          rd_d[CMD_CPL_BIT] = cpl_q;
        end
        REG_DIAG_CURRENT_CFG: begin
          rd_d = dcc_q;
        end
        REG_CHAN_STATE: begin
          rd_d = on_q;
        end
        REG_INT_STATUS: begin
          rd_d = stat_q;
        end
        REG_INT_MASK: begin
          rd_d = mask_q;
        end
        default: begin
          rd_d = '0;
        end
      endcase
    end
    irq_d = |(stat_d & mask_d);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_q <= '0;
      irq_q <= 1'b0;
    end else begin
      rd_q <= rd_d;
      irq_q <= irq_d;
    end
  end

  assign rd_data = rd_q;
  assign irq = irq_q;
  assign ch_on = on_q;
  assign diag_current_enable = dcc_q;
  assign protect_fault_flag = prot_q;
  assign open_load_flag = ol_q;

  // Check-side bounds of the two qualification delays
  localparam logic [12:0] OL_MIN_RUN = 13'(OPEN_LOAD_CYCLES);
  localparam logic [12:0] OL_MAX_RUN = 13'(OPEN_LOAD_DELAY_MAX_US * CLK_MHZ);
  localparam logic [12:0] OVL_MIN_RUN = 13'(OVERLOAD_CYCLES);
  localparam logic [12:0] OVL_MAX_RUN = 13'(OVERLOAD_OFF_DELAY_MAX_US * CLK_MHZ - SYNC_LAT - 1);

  // Check-side run lengths of the timed conditions, kept apart from the timers
  logic [NUM_CH-1:0][12:0] ol_run_q, ol_run_d;
  logic [NUM_CH-1:0][12:0] ovl_run_q, ovl_run_d;

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      ol_run_d[i] = ol_cond[i] ? ol_run_q[i] + 13'h0001 : 13'h0000;
      ovl_run_d[i] = ovl_cond[i] ? ovl_run_q[i] + 13'h0001 : 13'h0000;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ol_run_q <= '0;
      ovl_run_q <= '0;
    end else begin
      ol_run_q <= ol_run_d;
      ovl_run_q <= ovl_run_d;
    end
  end

  // Checks
  prot_hold_a: assert property (@(posedge clock) disable iff (rst) !cpl_clr |=> ($past(prot_q) & ~prot_q) == 8'h00)
    else $error("protection flag dropped without clear command");

  cpl_clear_a: assert property (@(posedge clock) disable iff (rst) cpl_clr |=> prot_q == $past(prot_set))
    else $error("clear command did not clear protection flags");

  cpl_self_a: assert property (@(posedge clock) disable iff (rst) cpl_q && frame_valid && !cpl_clr |=> !cpl_q)
    else $error("clear command bit not released by frame");

  ol_hold_a: assert property (@(posedge clock) disable iff (rst) !diag_rd |=> ($past(ol_q) & ~ol_q) == 8'h00)
    else $error("open-load flag dropped without diagnosis read");

  ol_read_a: assert property (@(posedge clock) disable iff (rst)
    reg_req.rd && reg_req.addr == REG_DIAG23 && ol_q[3] && !ol_set[3]
    |=> rd_data[DIAG_OL_ODD_BIT] && !ol_q[3])
    else $error("diagnosis read did not return and clear open-load flag");

  ol_on_a: assert property (@(posedge clock) disable iff (rst) on_q != 8'h00 |=> (ol_q & ~$past(ol_q) & $past(on_q)) == 8'h00)
    else $error("open-load flag set while channel on");

  ol_delay_a: assert property (@(posedge clock) disable iff (rst)
    (ol_q & ~$past(ol_q)) != 8'h00
    |-> (ol_q & ~$past(ol_q) & ~($past(ol_cond) & $past(ol_cond, 2) & ~$past(on_q))) == 8'h00)
    else $error("open-load flag set without qualified condition");

  dcc_write_a: assert property (@(posedge clock) disable iff (rst)
    reg_req.wr && reg_req.addr == REG_DIAG_CURRENT_CFG |=> diag_current_enable == $past(reg_req.wdata))
    else $error("diagnosis current enable not updated");

  overtemp_off_a: assert property (@(posedge clock) disable iff (rst)
    ot_s != 8'h00 |=> (($past(ot_s) & ~prot_q) == 8'h00) && (($past(ot_s) & ch_on) == 8'h00))
    else $error("over-temperature did not latch flag and force channel off");

  overload_off_a: assert property (@(posedge clock) disable iff (rst)
    ovl_done != 8'h00 |=> (($past(ovl_done) & ~prot_q) == 8'h00) && (($past(ovl_done) & ch_on) == 8'h00))
    else $error("qualified overload did not switch channel off");

  off_hold_a: assert property (@(posedge clock) disable iff (rst) (ch_on & prot_q) == 8'h00)
    else $error("protected channel is on");

  diag_map_a: assert property (@(posedge clock) disable iff (rst)
    reg_req.rd && reg_req.addr == REG_DIAG23
    |=> rd_data == {4'h0, $past(ol_q[3]), $past(prot_q[3]), $past(ol_q[2]), $past(prot_q[2])})
    else $error("diagnosis register layout wrong");

  irq_level_a: assert property (@(posedge clock) disable iff (rst) ##1 irq == |(stat_q & mask_q))
    else $error("interrupt output disagrees with status and mask");

  rd_idle_a: assert property (@(posedge clock) disable iff (rst) !reg_req.rd |=> rd_data == 8'h00)
    else $error("read data not zero outside the read answer cycle");

  stat_set_a: assert property (@(posedge clock) disable iff (rst) stat_ev != 8'h00 |=> (stat_q & $past(stat_ev)) == $past(stat_ev))
    else $error("status event lost against a clear");

  cpl_set_a: assert property (@(posedge clock) disable iff (rst) cpl_clr |=> cpl_q)
    else $error("clear command bit not set by its write");

  prot_set_a: assert property (@(posedge clock) disable iff (rst) prot_set != 8'h00 |=> (prot_q & $past(prot_set)) == $past(prot_set))
    else $error("protection event not latched");

  for (genvar i = 0; i < NUM_CH; i++) begin : g_delay_chk
    ol_min_a: assert property (@(posedge clock) disable iff (rst) $rose(ol_q[i]) |-> $past(ol_run_q[i]) >= OL_MIN_RUN)
      else $error("open-load flag set before the qualification delay");
    ol_max_a: assert property (@(posedge clock) disable iff (rst) ol_run_q[i] >= OL_MAX_RUN |-> ol_q[i])
      else $error("open-load flag missing after the qualification delay");
    ovl_min_a: assert property (@(posedge clock) disable iff (rst)
      $rose(prot_q[i]) && !$past(ot_s[i]) |-> $past(ovl_run_q[i]) >= OVL_MIN_RUN)
      else $error("overload latched before the qualification delay");
    ovl_max_a: assert property (@(posedge clock) disable iff (rst) ovl_run_q[i] <= OVL_MAX_RUN)
      else $error("overloaded channel not switched off in time");
  end

endmodule

/* test/host_model.sv */
// Host model that reaches the registers over the plain register port
`timescale 1ns/100ps
module host_model import diag_pkg::*; (
  // Clock
  input wire logic clock,
  // Register port
  output reg_req_t reg_req,
  input wire logic [DATA_W-1:0] rd_data
);
  initial begin
    reg_req = '0;
  end
  // One-cycle write strobe; a one to the clear bit acknowledges protection events
  task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    reg_req.wr <= 1'b0;
  endtask
  // One-cycle read strobe, data taken in the following cycle
  task automatic read_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clock);
    reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    reg_req.rd <= 1'b0;
    #1;
    d = rd_data;
  endtask
endmodule

/* test/tb.sv */
// Self-checking bench of the fault and diagnosis block
`timescale 1ns/100ps
module tb import diag_pkg::*; ();
  logic clock, rst, frame_valid, irq;
  logic [NUM_CH-1:0] ch_request, ch_on, diag_current_enable, protect_fault_flag, open_load_flag;
  logic [DATA_W-1:0] rd_data, rv;
  reg_req_t reg_req;
  fault_in_t fault_pins;
  int n_mismatch, total_checks, n;

  power_switch_fault_diagnosis u_dut (.clock(clock), .rst(rst), .reg_req(reg_req), .rd_data(rd_data),
    .frame_valid(frame_valid), .ch_request(ch_request), .fault_pins(fault_pins), .ch_on(ch_on),
    .diag_current_enable(diag_current_enable), .protect_fault_flag(protect_fault_flag),
    .open_load_flag(open_load_flag), .irq(irq));
  host_model u_host (.clock(clock), .reg_req(reg_req), .rd_data(rd_data));

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Counts cycles until one flag rises, bounded by lim
  task automatic wait_flag(input bit ol, input int ch, input int lim, output int cnt);
    cnt = 0;
    while ((ol ? open_load_flag[ch] : protect_fault_flag[ch]) !== 1'b1 && cnt < lim) begin
      @(posedge clock);
      #1;
      cnt++;
    end
    if (cnt >= lim) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, 1'b0, 1'b1);
      print_verdict();
    end
  endtask

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  initial begin
    #2000000;
    n_mismatch++;
    print_verdict();
  end

  initial begin
    rst = 1'b1;
    frame_valid = 1'b0;
    ch_request = '0;
    fault_pins = '0;
    n_mismatch = 0;
    total_checks = 0;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    // Values after reset, unmapped address included
    for (int a = 0; a < 10; a++) begin
      u_host.read_reg(ADDR_W'(a), rv);
      chk(rv, 8'h00);
    end
    u_host.write_reg(REG_DIAG_CURRENT_CFG, 8'hA5);
    u_host.read_reg(REG_DIAG_CURRENT_CFG, rv);
    chk(rv, 8'hA5);
    chk(diag_current_enable, 8'hA5);
    u_host.write_reg(REG_DIAG01, 8'hFF);
    u_host.write_reg(REG_INT_MASK, 8'h03);
    @(posedge clock);
    ch_request <= 8'hFB;
    repeat (3) @(posedge clock);
    #1;
    chk(ch_on, 8'hFB);
    // Over-temperature on an active and an off channel
    @(posedge clock);
    fault_pins.overtemp <= 8'h05;
    wait_flag(0, 0, 8, n);
    repeat (2) @(posedge clock);
    #1;
    chk(protect_fault_flag, 8'h05);
    chk(ch_on, 8'hFA);
    chk({7'h00, irq}, 8'h01);
    @(posedge clock);
    fault_pins.overtemp <= 8'h00;
    repeat (10) @(posedge clock);
    #1;
    chk(ch_on, 8'hFA);
    chk(protect_fault_flag, 8'h05);
    u_host.read_reg(REG_DIAG01, rv);
    chk(rv, 8'h01);
    u_host.read_reg(REG_DIAG23, rv);
    chk(rv, 8'h01);
    u_host.write_reg(REG_INT_STATUS, 8'h01);
    @(posedge clock);
    #1;
    chk({7'h00, irq}, 8'h00);
    // Clear command and its self-clearing bit
    u_host.write_reg(REG_CMD, 8'h01);
    repeat (2) @(posedge clock);
    #1;
    chk(protect_fault_flag, 8'h00);
    chk(ch_on, 8'hFB);
    u_host.read_reg(REG_CMD, rv);
    chk(rv, 8'h01);
    @(posedge clock);
    frame_valid <= 1'b1;
    @(posedge clock);
    frame_valid <= 1'b0;
    u_host.read_reg(REG_CMD, rv);
    chk(rv, 8'h00);
    // Overload that drops out once, then holds until shutdown
    @(posedge clock);
    fault_pins.overload <= 8'h02;
    repeat (900) @(posedge clock);
    fault_pins.overload <= 8'h00;
    repeat (10) @(posedge clock);
    #1;
    chk(protect_fault_flag, 8'h00);
    @(posedge clock);
    fault_pins.overload <= 8'h02;
    wait_flag(0, 1, 1300, n);
    chk({7'h00, n <= 1200 && n >= OVERLOAD_CYCLES}, 8'h01);
    repeat (2) @(posedge clock);
    #1;
    chk(ch_on, 8'hF9);
    @(posedge clock);
    fault_pins.overload <= 8'h00;
    // Open load is ignored while on, then qualified while off
    fault_pins.open_load <= 8'h08;
    repeat (2100) @(posedge clock);
    #1;
    chk(open_load_flag, 8'h00);
    @(posedge clock);
    ch_request <= 8'hF3;
    wait_flag(1, 3, 5100, n);
    chk({7'h00, n >= OPEN_LOAD_CYCLES && n <= 5000}, 8'h01);
    @(posedge clock);
    fault_pins.open_load <= 8'h00;
    repeat (10) @(posedge clock);
    #1;
    chk(open_load_flag, 8'h08);
    u_host.read_reg(REG_DIAG23, rv);
    chk(rv, 8'h08);
    u_host.read_reg(REG_DIAG23, rv);
    chk(rv, 8'h00);
    u_host.read_reg(REG_CHAN_STATE, rv);
    chk(rv, 8'hF1);
    u_host.read_reg(REG_INT_STATUS, rv);
    chk(rv, 8'h03);
    u_host.write_reg(REG_INT_STATUS, 8'hFF);
    @(posedge clock);
    #1;
    chk({7'h00, irq}, 8'h00);
    print_verdict();
  end
endmodule
